/* File: perf_monitor_pin_interface_tb.sv */
// Self-checking bench joining host and device ends
`timescale 1ns/1ns
module perf_monitor_pin_interface_tb;
    import pmpi_pkg::*;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              req = 1'b0;
    logic              req_read = 1'b0;
    logic [ADDR_W-1:0] req_addr = '0;
    logic [DATA_W-1:0] req_wdata = '0;
    logic [2:0]        req_cpu = '0;
    logic              hold_req = 1'b0;
    logic              sink_ready = 1'b0;
    logic              diag_on = 1'b0;
    logic              outputs_off = 1'b0;
    logic              wait_long = 1'b0;
    logic [EVT_W-1:0]  events = '0;
    logic              ts_clk_in = 1'b0;
    logic              busy, done, net_valid, net_last, net_perr;
    logic [DATA_W-1:0] rdata, wd;
    logic [NET_W-1:0]  net_data;
    logic [CNT_W-1:0]  timestamp, t0;
    logic [CPU_W-1:0]  last_writer;
    logic [31:0]       seed = 32'hd746;
    logic [31:0]       cnt [16];
    logic [DATA_W:0]   exp_q [$];
    logic [DATA_W:0]   e;
    logic              ts_run = 1'b0;
    logic              quiet = 1'b0;
    int                failures = 0, comparisons = 0, cycles = 0, lat, lat0, nidx, ts_rises;

    pmpi_if ifc ();
    pmpi_host i_pmpi_host (.clk(clk), .rst(rst), .pins(ifc), .req(req), .req_read(req_read),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_cpu(req_cpu), .hold_req(hold_req),
        .sink_ready(sink_ready), .diag_on(diag_on), .outputs_off(outputs_off), .wait_long(wait_long),
        .events(events), .ts_clk_in(ts_clk_in), .busy(busy), .done(done), .rdata(rdata),
        .net_valid(net_valid), .net_data(net_data), .net_last(net_last), .net_perr(net_perr));
    pmpi_device i_pmpi_device (.clk(clk), .rst(rst), .pins(ifc), .timestamp(timestamp),
        .last_writer(last_writer));
    pmpi_chk i_pmpi_chk (.clk(clk), .rst(rst), .rd_strobe_n(ifc.rd_strobe_n), .wr_strobe_n(ifc.wr_strobe_n),
        .read_extend_n(ifc.read_extend_n), .cycle_done_n(ifc.cycle_done_n), .cycle_done_oe(ifc.cycle_done_oe),
        .host_data_oe_d(ifc.host_data_oe_d), .outputs_off_n(ifc.outputs_off_n), .net_out_bus(ifc.net_out_bus),
        .net_parity(ifc.net_parity), .packet_last(ifc.packet_last), .net_data_avail_n(ifc.net_data_avail_n),
        .fifo_side_clock(ifc.fifo_side_clock), .net_oe(ifc.net_oe), .fifo_can_accept(ifc.fifo_can_accept));

    // ----------------------------------------
    // Clocks, stimulus helpers, monitors
    // ----------------------------------------
    always #5 clk = ~clk;

    always
    begin
        #62 ts_clk_in = ts_run;
        #63 ts_clk_in = 1'b0;
    end

    always @(posedge ts_clk_in)
        ts_rises++;

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        lfsr_next = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    always @(posedge clk)
    begin
        seed <= lfsr_next(seed);
        sink_ready <= (seed[3] | seed[7]) & ~quiet;
    end

    task automatic chk(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic bus(input logic rd, input logic [7:0] a, input logic [63:0] d, input int c,
                       input logic [63:0] exp);
        int n;
        n = 0;
        exp_q.push_back({rd, exp});
        req <= 1'b1;
        req_read <= rd;
        req_addr <= a;
        req_wdata <= d;
        req_cpu <= c[2:0];
        do
        begin
            @(posedge clk);
            n++;
        end while (!busy && n < 40);
        req <= 1'b0;
        while (!done && n < 80)
        begin
            @(posedge clk);
            n++;
        end
        lat = n;
        @(posedge clk);
    endtask

    task automatic pulse(input int j, input int n);
        repeat (n)
        begin
            events[j] <= 1'b1;
            repeat (3) @(posedge clk);
            events[j] <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask

    always @(posedge clk)
    begin
        if (!rst && done && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            if (e[DATA_W])
                chk("rdata", e[DATA_W-1:0], rdata);
        end
        if (rst)
            nidx = 0;
        else if (net_valid)
        begin
            chk("net_perr", 64'h0, {63'h0, net_perr});
            chk("net_last", {63'h0, nidx % PKT_LEN == PKT_LEN - 1}, {63'h0, net_last});
            nidx++;
        end
        cycles++;
        if (cycles == 8000)
        begin
            failures++;
            give_verdict();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (12) @(posedge clk);
        bus(1, 8'h40, 0, 0, 64'h0);
        lat0 = lat;
        diag_on <= 1'b1;
        repeat (4) @(posedge clk);
        for (int c = 0; c < 8; c++)
        begin
            wd = {lfsr_next(seed), seed};
            cnt[c] = wd[31:0];
            bus(0, 8'h40 + 8'(c), wd, c, 64'h0);
            chk("last_writer", 64'h1 << c, {56'h0, last_writer});
        end
        for (int c = 0; c < 8; c++)
            bus(1, 8'h40 + 8'(c), 0, 0, {32'h0, cnt[c]});
        pulse(0, 3);
        bus(1, 8'h40, 0, 0, {32'h0, cnt[0]});
        diag_on <= 1'b0;
        repeat (4) @(posedge clk);
        for (int c = 0; c < 4; c++)
            pulse(c, c + 1);
        for (int c = 0; c < 4; c++)
            bus(1, 8'h40 + 8'(c), 0, 0, {32'h0, cnt[c] + 32'(c + 1)});
        hold_req <= 1'b1;
        fork
            begin
                repeat (10) @(posedge clk);
                hold_req <= 1'b0;
            end
        join_none
        bus(1, 8'h41, 0, 0, {32'h0, cnt[1] + 32'h2});
        t0 = timestamp;
        ts_rises = 0;
        ts_run = 1'b1;
        repeat (200) @(posedge clk);
        ts_run = 1'b0;
        repeat (30) @(posedge clk);
        chk("timestamp", {32'h0, t0 + 32'(ts_rises)}, {32'h0, timestamp});
        quiet <= 1'b1;
        repeat (8) @(posedge clk);
        outputs_off <= 1'b1;
        repeat (20) @(posedge clk);
        outputs_off <= 1'b0;
        repeat (8) @(posedge clk);
        quiet <= 1'b0;
        rst <= 1'b1;
        wait_long <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (12) @(posedge clk);
        wait_long <= 1'b0;
        bus(1, 8'h40, 0, 0, 64'h0);
        chk("wait_lat", 64'(lat0 + 2), 64'(lat));
        bus(0, 8'h43, {seed, seed}, 7, 64'h0);
        chk("wait_lat", 64'(lat0 + 2), 64'(lat));
        repeat (100) @(posedge clk);
        chk("net_words", 64'h1, {63'h0, nidx >= 8});
        give_verdict();
    end
endmodule // perf_monitor_pin_interface_tb

/* File: pmpi_chk.sv */
// Concurrent checks on the monitor pin interface
`timescale 1ns/1ns
module pmpi_chk
    import pmpi_pkg::*;
(
    input wire logic             clk,
    input wire logic             rst,
    input wire logic             rd_strobe_n,
    input wire logic             wr_strobe_n,
    input wire logic             read_extend_n,
    input wire logic             cycle_done_n,
    input wire logic             cycle_done_oe,
    input wire logic             host_data_oe_d,
    input wire logic             outputs_off_n,
    input wire logic [NET_W-1:0] net_out_bus,
    input wire logic             net_parity,
    input wire logic             packet_last,
    input wire logic             net_data_avail_n,
    input wire logic             fifo_side_clock,
    input wire logic             net_oe,
    input wire logic             fifo_can_accept
);
    logic rd_cyc_reg;
    logic rd_cyc_next;

    // ----------------------------------------
    // Cycle kind tracker
    // ----------------------------------------
    always_comb
    begin
        rd_cyc_next = rd_cyc_reg;
        if (!rd_strobe_n)
            rd_cyc_next = 1'b1;
        else if (!wr_strobe_n)
            rd_cyc_next = 1'b0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rd_cyc_reg <= 1'b0;
        else
            rd_cyc_reg <= rd_cyc_next;
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_ack_in_cycle;
        $fell(cycle_done_n) |-> (!rd_strobe_n || !wr_strobe_n);
    endproperty
    a_ack_in_cycle: assert property (p_ack_in_cycle) else $error("ack without strobe");

    property p_rd_start;
        $fell(rd_strobe_n) |-> ##[2:8] $fell(cycle_done_n);
    endproperty
    a_rd_start: assert property (p_rd_start) else $error("read not answered");

    property p_wr_start;
        $fell(wr_strobe_n) |-> ##[2:8] $fell(cycle_done_n);
    endproperty
    a_wr_start: assert property (p_wr_start) else $error("write not answered");

    property p_wr_ack_short;
        $fell(cycle_done_n) && !rd_cyc_reg |=> cycle_done_n;
    endproperty
    a_wr_ack_short: assert property (p_wr_ack_short) else $error("write ack too long");

    property p_hold_keep;
        (!read_extend_n)[*4] ##0 (!cycle_done_n && rd_cyc_reg) |=> !cycle_done_n && host_data_oe_d;
    endproperty
    a_hold_keep: assert property (p_hold_keep) else $error("hold not honoured");

    property p_data_with_ack;
        host_data_oe_d |-> !cycle_done_n;
    endproperty
    a_data_with_ack: assert property (p_data_with_ack) else $error("data driven without ack");

    property p_parity;
        net_oe |-> (net_parity == ~(^net_out_bus));
    endproperty
    a_parity: assert property (p_parity) else $error("parity not odd");

    property p_hold_word;
        (!fifo_can_accept)[*4] ##0 !net_data_avail_n |=> $stable(net_out_bus) && $stable(packet_last);
    endproperty
    a_hold_word: assert property (p_hold_word) else $error("word changed while not ready");

    property p_net_clock;
        $rose(fifo_side_clock) ##1 net_oe[*4] |-> $rose(fifo_side_clock);
    endproperty
    a_net_clock: assert property (p_net_clock) else $error("network clock period wrong");

    property p_out_off;
        (!outputs_off_n)[*4] |-> !net_oe && !host_data_oe_d && !cycle_done_oe;
    endproperty
    a_out_off: assert property (p_out_off) else $error("output driven while disabled");

    property p_reset_idle;
        $fell(rst) |-> cycle_done_n && net_data_avail_n;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("outputs active out of reset");
endmodule // pmpi_chk

/* File: pmpi_device.sv */
// Monitor device end: processor port, event counters, network output
// Functional notes
// - Acknowledge low marks end of cycle
// - Host asserts at most one identity line
// - Hold keeps read data and acknowledge
// - Qualifier combines with strobe to start
// - Read strobe low starts read cycle
// - Write strobe low starts write cycle
// - Async reset held five clocks minimum
// - Test mode freezes counters, allows writes
// - Wait states latched only during reset
// - Event inputs counted on rising edge
// - Timestamp clock at most third node
// - Everything synchronised to node clock; address, data and identity lines are used without synchronisers
// - Data-available low when word present
// - Fifo ready high only when accepting
// - Device generates network clock output
// - Odd parity beside each byte
// - End-of-message marks final packet word
// - Output-disable releases all output pins
// - Names ending _n are active low
// - Eight data, parity, end-of-message bits
`timescale 1ns/1ns
module pmpi_device
    import pmpi_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst,
    pmpi_if.device               pins,
    output logic [CNT_W-1:0]     timestamp,
    output logic [CPU_W-1:0]     last_writer
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    localparam int SW = 8;
    logic [SW-1:0]    s1_reg;
    logic [SW-1:0]    s2_reg;
    logic [EVT_W-1:0] e1_reg;
    logic [EVT_W-1:0] e2_reg;
    logic [EVT_W-1:0] e3_reg;
    logic             r1_reg;
    logic             r2_reg;
    logic             ts_old_reg;
    logic             rd_n;
    logic             q_n;
    logic             hold_n;
    logic             test_n;
    logic             off_n;
    logic             ws_in;
    logic             rdy;
    logic             ts_s;
    logic             in_reset;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1_reg     <= '0;
            s2_reg     <= '0;
            e1_reg     <= '0;
            e2_reg     <= '0;
            e3_reg     <= '0;
            r1_reg     <= 1'b0;
            r2_reg     <= 1'b0;
            ts_old_reg <= 1'b0;
        end
        else
        begin
            s1_reg     <= {pins.timestamp_clk, pins.fifo_can_accept, pins.wait_cycles_cfg,
                           pins.outputs_off_n, pins.diag_mode_n, pins.read_extend_n,
                           pins.txn_qualifier_n | (pins.rd_strobe_n & pins.wr_strobe_n),
                           pins.rd_strobe_n};
            s2_reg     <= s1_reg;
            e1_reg     <= pins.event_inputs;
            e2_reg     <= e1_reg;
            e3_reg     <= e2_reg;
            r1_reg     <= pins.async_rst_n;
            r2_reg     <= r1_reg;
            ts_old_reg <= s2_reg[7];
        end
    end
    assign rd_n     = s2_reg[0];
    assign q_n      = s2_reg[1];
    assign hold_n   = s2_reg[2];
    assign test_n   = s2_reg[3];
    assign off_n    = s2_reg[4];
    assign ws_in    = s2_reg[5];
    assign rdy      = s2_reg[6];
    assign ts_s     = s2_reg[7];
    assign in_reset = ~r2_reg;

    // ----------------------------------------
    // Processor cycle machine
    // ----------------------------------------
    pmpi_bus_e             st_reg, st_next;
    logic [WAIT_W-1:0]     ws_reg, ws_next;
    logic [WAIT_W-1:0]     wc_reg, wc_next;
    logic                  is_rd_reg, is_rd_next;
    logic [DATA_W-1:0]     rdata_reg, rdata_next;
    logic [CPU_W-1:0]      writer_reg, writer_next;
    logic [CNT_W-1:0]      ts_reg, ts_next;
    logic [CNT_W-1:0]      cnt_reg [EVT_W];
    logic [CNT_W-1:0]      cnt_next [EVT_W];
    logic [3:0]            idx;
    assign idx = pins.host_addr_bus[3:0];
    always_comb
    begin
        st_next     = st_reg;
        ws_next     = ws_reg;
        wc_next     = wc_reg;
        is_rd_next  = is_rd_reg;
        rdata_next  = rdata_reg;
        writer_next = writer_reg;
        ts_next     = ts_reg + CNT_W'(ts_s & ~ts_old_reg);
        cnt_next    = cnt_reg;
        for (int i = 0; i < EVT_W; i++)
            if (test_n && e2_reg[i] && !e3_reg[i])
                cnt_next[i] = cnt_reg[i] + 32'h1;
        if (in_reset)
        begin
            ws_next = ws_in ? WAIT_LONG : WAIT_SHORT;
            st_next = PMPI_IDLE;
            for (int i = 0; i < EVT_W; i++)
                cnt_next[i] = '0;
        end
        else
        begin
            unique case (st_reg)
                PMPI_IDLE:
                    if (!q_n)
                    begin
                        is_rd_next = ~rd_n;
                        wc_next    = ws_reg;
                        st_next    = PMPI_WAIT;
                    end
                PMPI_WAIT:
                    if (wc_reg == WAIT_SHORT)
                    begin
                        if (is_rd_reg)
                            rdata_next = (pins.host_addr_bus[7:4] == ADDR_CNT_BASE_HI)
                                       ? DATA_W'(cnt_reg[idx]) : DATA_W'(ts_reg);
                        else
                        begin
                            writer_next = pins.cpu_ident_lines;
                            if (!test_n && pins.host_addr_bus[7:4] == ADDR_CNT_BASE_HI)
                                cnt_next[idx] = pins.host_data_bus[CNT_W-1:0];
                        end
                        st_next = PMPI_ACK;
                    end
                    else
                        wc_next = wc_reg - 4'h1;
                PMPI_ACK:
                    if (!(is_rd_reg && !hold_n))
                        st_next = PMPI_DONE;
                PMPI_DONE:
                    if (q_n)
                        st_next = PMPI_IDLE;
            endcase
        end
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_reg     <= PMPI_IDLE;
            ws_reg     <= WAIT_SHORT;
            wc_reg     <= WAIT_SHORT;
            is_rd_reg  <= 1'b0;
            rdata_reg  <= '0;
            writer_reg <= '0;
            ts_reg     <= '0;
            for (int i = 0; i < EVT_W; i++)
                cnt_reg[i] <= '0;
        end
        else
        begin
            st_reg     <= st_next;
            ws_reg     <= ws_next;
            wc_reg     <= wc_next;
            is_rd_reg  <= is_rd_next;
            rdata_reg  <= rdata_next;
            writer_reg <= writer_next;
            ts_reg     <= ts_next;
            cnt_reg    <= cnt_next;
        end
    end
    assign pins.cycle_done_n    = ~(st_reg == PMPI_ACK);
    assign pins.cycle_done_oe   = off_n;
    assign pins.host_data_out_d = rdata_reg;
    assign pins.host_data_oe_d  = off_n && is_rd_reg && st_reg == PMPI_ACK;
    assign timestamp            = ts_reg;
    assign last_writer          = writer_reg;

    // ----------------------------------------
    // Network output port
    // ----------------------------------------
    logic [NET_DIV_W-1:0] dv_reg, dv_next;
    logic                 nclk_reg, nclk_next;
    logic [NET_W-1:0]     nd_reg, nd_next;
    logic                 np_reg, np_next;
    logic                 nl_reg, nl_next;
    logic                 nv_reg, nv_next;
    logic [PKT_W-1:0]     pk_reg, pk_next;
    logic                 fall;
    assign fall = (dv_reg == NET_DIV_W'(NET_DIV - 1));
    always_comb
    begin
        dv_next   = dv_reg + 2'h1;
        nclk_next = (dv_reg == NET_DIV_W'(NET_DIV/2 - 1)) ? 1'b1 : (fall ? 1'b0 : nclk_reg);
        nd_next   = nd_reg;
        np_next   = np_reg;
        nl_next   = nl_reg;
        nv_next   = nv_reg;
        pk_next   = pk_reg;
        if (fall && (rdy || !nv_reg))
        begin
            nv_next = 1'b1;
            nd_next = ts_reg[NET_W-1:0] ^ NET_W'(pk_reg);
            np_next = odd_parity(ts_reg[NET_W-1:0] ^ NET_W'(pk_reg));
            nl_next = (pk_reg == PKT_W'(PKT_LEN - 1));
            pk_next = pk_reg + 2'h1;
        end
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            dv_reg   <= '0;
            nclk_reg <= 1'b0;
            nd_reg   <= '0;
            np_reg   <= 1'b1;
            nl_reg   <= 1'b0;
            nv_reg   <= 1'b0;
            pk_reg   <= '0;
        end
        else
        begin
            dv_reg   <= dv_next;
            nclk_reg <= nclk_next;
            nd_reg   <= nd_next;
            np_reg   <= np_next;
            nl_reg   <= nl_next;
            nv_reg   <= nv_next;
            pk_reg   <= pk_next;
        end
    end
    assign pins.net_out_bus      = nd_reg;
    assign pins.net_parity       = np_reg;
    assign pins.packet_last      = nl_reg;
    assign pins.net_data_avail_n = ~nv_reg;
    assign pins.fifo_side_clock  = nclk_reg;
    assign pins.net_oe           = off_n;
endmodule // pmpi_device

/* File: pmpi_host.sv */
// Host end: processor bus master and external network fifo sink
`timescale 1ns/1ns
module pmpi_host
    import pmpi_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    pmpi_if.host                   pins,
    input  wire logic              req,
    input  wire logic              req_read,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    input  wire logic [2:0]        req_cpu,
    input  wire logic              hold_req,
    input  wire logic              sink_ready,
    input  wire logic              diag_on,
    input  wire logic              outputs_off,
    input  wire logic              wait_long,
    input  wire logic [EVT_W-1:0]  events,
    input  wire logic              ts_clk_in,
    output logic                   busy,
    output logic                   done,
    output logic [DATA_W-1:0]      rdata,
    output logic                   net_valid,
    output logic [NET_W-1:0]       net_data,
    output logic                   net_last,
    output logic                   net_perr
);
    // ----------------------------------------
    // Synchronisers
    // ----------------------------------------
    logic [2:0] a1_reg;
    logic [2:0] a2_reg;
    logic [DATA_W-1:0] d1_reg;
    logic [DATA_W-1:0] d2_reg;
    logic       nc_old_reg;
    logic [3:0] rc_reg, rc_next;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            a1_reg     <= 3'h5;
            a2_reg     <= 3'h5;
            d1_reg     <= '0;
            d2_reg     <= '0;
            nc_old_reg <= 1'b0;
        end
        else
        begin
            a1_reg     <= {pins.net_data_avail_n, pins.fifo_side_clock, pins.cycle_done_n};
            a2_reg     <= a1_reg;
            d1_reg     <= pins.host_data_bus;
            d2_reg     <= d1_reg;
            nc_old_reg <= a2_reg[1];
        end
    end

    // ----------------------------------------
    // Bus master and reset stretch
    // ----------------------------------------
    logic act_reg, act_next;
    logic rd_reg, rd_next;
    logic dn_reg, dn_next;
    logic [DATA_W-1:0] rdat_reg, rdat_next;
    always_comb
    begin
        act_next  = act_reg;
        rd_next   = rd_reg;
        dn_next   = 1'b0;
        rdat_next = rdat_reg;
        rc_next   = (rc_reg == 4'(RST_MIN_CLKS + 1)) ? rc_reg : rc_reg + 4'h1;
        if (!act_reg && req && rc_reg == 4'(RST_MIN_CLKS + 1))
        begin
            act_next = 1'b1;
            rd_next  = req_read;
        end
        else if (act_reg && !a2_reg[0] && !hold_req)
        begin
            act_next  = 1'b0;
            dn_next   = 1'b1;
            rdat_next = d2_reg;
        end
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            act_reg  <= 1'b0;
            rd_reg   <= 1'b0;
            dn_reg   <= 1'b0;
            rdat_reg <= '0;
            rc_reg   <= '0;
        end
        else
        begin
            act_reg  <= act_next;
            rd_reg   <= rd_next;
            dn_reg   <= dn_next;
            rdat_reg <= rdat_next;
            rc_reg   <= rc_next;
        end
    end
    assign pins.async_rst_n     = (rc_reg >= 4'(RST_MIN_CLKS));
    assign pins.rd_strobe_n     = ~(act_reg & rd_reg);
    assign pins.wr_strobe_n     = ~(act_reg & ~rd_reg);
    assign pins.txn_qualifier_n = ~act_reg;
    assign pins.read_extend_n   = ~(act_reg & rd_reg & hold_req);
    assign pins.host_addr_bus   = req_addr;
    assign pins.host_data_out_h = req_wdata;
    assign pins.host_data_oe_h  = act_reg & ~rd_reg;
    assign pins.cpu_ident_lines = (act_reg & ~rd_reg) ? CPU_W'(8'h01 << req_cpu) : '0;
    assign pins.diag_mode_n     = ~diag_on;
    assign pins.outputs_off_n   = ~outputs_off;
    assign pins.wait_cycles_cfg = wait_long;
    assign pins.event_inputs    = events;
    assign pins.timestamp_clk   = ts_clk_in;
    assign pins.fifo_can_accept = rdy_reg;
    assign busy                 = act_reg;
    assign done                 = dn_reg;
    assign rdata                = rdat_reg;

    // ----------------------------------------
    // Fifo capture on network clock rise
    // ----------------------------------------
    logic nv_reg, nv_next;
    logic [NET_W-1:0] nd_reg, nd_next;
    logic nl_reg, nl_next;
    logic pe_reg, pe_next;
    logic rdy_reg, rdy_next;
    always_comb
    begin
        nv_next = 1'b0;
        nd_next = nd_reg;
        nl_next = nl_reg;
        pe_next = pe_reg;
        rdy_next = rdy_reg;
        if (a2_reg[1] && !nc_old_reg && !a2_reg[2])
        begin
            nv_next = sink_ready;
            rdy_next = sink_ready;
            nd_next = pins.net_out_bus;
            nl_next = pins.packet_last;
            pe_next = (odd_parity(pins.net_out_bus) != pins.net_parity);
        end
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            nv_reg <= 1'b0;
            nd_reg <= '0;
            nl_reg <= 1'b0;
            pe_reg <= 1'b0;
            rdy_reg <= 1'b0;
        end
        else
        begin
            nv_reg <= nv_next;
            nd_reg <= nd_next;
            nl_reg <= nl_next;
            pe_reg <= pe_next;
            rdy_reg <= rdy_next;
        end
    end
    assign net_valid = nv_reg;
    assign net_data  = nd_reg;
    assign net_last  = nl_reg;
    assign net_perr  = pe_reg;
endmodule // pmpi_host

/* File: pmpi_if.sv */
// Pin-level interface between monitor device and its host side
`timescale 1ns/1ns
interface pmpi_if;
    import pmpi_pkg::*;
    logic              rd_strobe_n;
    logic              wr_strobe_n;
    logic              txn_qualifier_n;
    logic              read_extend_n;
    logic              cycle_done_n;
    logic              cycle_done_oe;
    logic [ADDR_W-1:0] host_addr_bus;
    logic [DATA_W-1:0] host_data_out_h;
    logic              host_data_oe_h;
    logic [DATA_W-1:0] host_data_out_d;
    logic              host_data_oe_d;
    logic [CPU_W-1:0]  cpu_ident_lines;
    logic              async_rst_n;
    logic              diag_mode_n;
    logic              outputs_off_n;
    logic              wait_cycles_cfg;
    logic [EVT_W-1:0]  event_inputs;
    logic              timestamp_clk;
    logic [NET_W-1:0]  net_out_bus;
    logic              net_parity;
    logic              packet_last;
    logic              net_data_avail_n;
    logic              fifo_side_clock;
    logic              net_oe;
    logic              fifo_can_accept;
    wire  [DATA_W-1:0] host_data_bus = host_data_oe_d ? host_data_out_d :
                                       host_data_oe_h ? host_data_out_h : '0;

    modport device
    (
        input  rd_strobe_n, wr_strobe_n, txn_qualifier_n, read_extend_n, host_addr_bus,
        input  host_data_out_h, host_data_oe_h, cpu_ident_lines, async_rst_n, diag_mode_n,
        input  outputs_off_n, wait_cycles_cfg, event_inputs, timestamp_clk, fifo_can_accept, host_data_bus,
        output cycle_done_n, cycle_done_oe, host_data_out_d, host_data_oe_d, net_out_bus,
        output net_parity, packet_last, net_data_avail_n, fifo_side_clock, net_oe
    );
    modport host
    (
        output rd_strobe_n, wr_strobe_n, txn_qualifier_n, read_extend_n, host_addr_bus,
        output host_data_out_h, host_data_oe_h, cpu_ident_lines, async_rst_n, diag_mode_n,
        output outputs_off_n, wait_cycles_cfg, event_inputs, timestamp_clk, fifo_can_accept,
        input  cycle_done_n, cycle_done_oe, host_data_out_d, host_data_oe_d, net_out_bus,
        input  net_parity, packet_last, net_data_avail_n, fifo_side_clock, net_oe, host_data_bus
    );
endinterface

/* File: pmpi_pkg.sv */
// Shared constants and types for the monitor pin interface
package pmpi_pkg;
    localparam int DATA_W        = 64;
    localparam int ADDR_W        = 8;
    localparam int CPU_W         = 8;
    localparam int EVT_W         = 16;
    localparam int NET_W         = 8;
    localparam int WAIT_W        = 4;
    localparam int CNT_W         = 32;
    localparam int RST_MIN_CLKS  = 5;
    localparam int NET_DIV       = 4;
    localparam int NET_DIV_W     = 2;
    localparam int PKT_LEN       = 4;
    localparam int PKT_W         = 2;
    localparam logic [WAIT_W-1:0] WAIT_SHORT = 4'h0;
    localparam logic [WAIT_W-1:0] WAIT_LONG  = 4'h2;
    localparam logic [3:0] ADDR_CNT_BASE_HI = 4'h4;
    localparam logic [3:0] ADDR_SAMPLE_HI   = 4'h6;
    localparam logic [3:0] ADDR_PKT_HI      = 4'h7;

    typedef enum logic [3:0]
    {
        PMPI_IDLE = 4'h1,
        PMPI_WAIT = 4'h2,
        PMPI_ACK  = 4'h4,
        PMPI_DONE = 4'h8
    } pmpi_bus_e;

    function automatic logic odd_parity(input logic [NET_W-1:0] d);
        odd_parity = ~(^d);
    endfunction
endpackage
